// ### core/irq_ctrl.v
// interrupt controller with stack sequencing for a small 8-bit core
// Functional notes
// - Four request sources: external pin, comparator, 16-bit timer, 8-bit timer.
// - Each source has its own enable bit gating whether its flag can cause an interrupt.
// - Flags are set by hardware only and cleared when software writes zero to a bit.
// - The edge select picks rising, falling or either edge per source to set its flag.
// - Global enable set by the enable instruction, cleared by the disable instruction.
// - The stack lives in data memory at the stack pointer, whose bit 0 stays zero.
// - Push and pop instructions save accumulator and flags in two bytes of stack.
// - On entry the pc is written at sp, sp gains two, global enable clears, fetch at 0x010.
// - Return restores pc from the stack, sp loses two, global enable sets again.
// - The request flag register is readable to identify the pending sources.
// - A source event sets its flag even when that source is disabled.
// - The 16-bit timer request sits at flag bit 2.
`timescale 1ns/100ps
`include "irq_ctrl_defines.vh"
module irq_ctrl (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_external_pin_source,
  input  wire        i_comparator_source,
  input  wire        i_sixteen_bit_timer_source,
  input  wire        i_eight_bit_timer_source,
  input  wire        i_enable_wr,
  input  wire [3:0]  i_enable_wdata,
  input  wire        i_edge_wr,
  input  wire [7:0]  i_edge_wdata,
  input  wire        i_flag_wr,
  input  wire [3:0]  i_flag_wdata,
  input  wire        i_sp_wr,
  input  wire [7:0]  i_sp_wdata,
  input  wire        i_engint,
  input  wire        i_disgint,
  input  wire        i_boundary,
  input  wire [15:0] i_pc,
  input  wire        i_reti,
  input  wire        i_push,
  input  wire        i_pop,
  input  wire [7:0]  i_accumulator,
  input  wire [7:0]  i_status_flags,
  input  wire [7:0]  i_mem_rdata,
  output wire [3:0]  o_irq_flags,
  output wire [3:0]  o_irq_enable_reg,
  output wire [7:0]  o_edge_select,
  output wire [7:0]  o_stack_pointer_reg,
  output wire        o_global_enable,
  output wire        o_busy,
  output reg         o_take,
  output reg         o_pc_load,
  output reg  [15:0] o_pc_value,
  output reg         o_acc_load,
  output reg  [7:0]  o_acc_value,
  output reg         o_sflag_load,
  output reg  [7:0]  o_sflag_value,
  output reg         o_mem_we,
  output reg  [7:0]  o_mem_addr,
  output reg  [7:0]  o_mem_wdata
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_ENT1  = 3'h1;
  localparam ST_RET0  = 3'h2;
  localparam ST_RET1  = 3'h3;
  localparam ST_PUSH1 = 3'h4;
  localparam ST_POP0  = 3'h5;
  localparam ST_POP1  = 3'h6;
  localparam ST_RET2  = 3'h7;

  reg  [3:0] flags;
  reg  [3:0] irq_enable_reg;
  reg  [7:0] edge_sel;
  reg  [7:0] stack_pointer_reg;
  reg        gie;
  reg  [2:0] state;
  reg  [7:0] lo_byte;
  reg  [15:0] save_pc;
  reg  [7:0] save_sflag;
  wire [3:0] src_raw;
  wire [3:0] hit;
  wire       pending;
  wire       start_entry;
  wire       start_reti;
  wire       start_push;
  wire       start_pop;
  reg  [2:0] next_state;
  reg  [7:0] next_sp;
  reg        next_gie;

  // source order fixes the sixteen_bit_timer_source flag at bit 2
  assign src_raw = {i_eight_bit_timer_source, i_sixteen_bit_timer_source,
                    i_comparator_source, i_external_pin_source};

  genvar g;
  generate
    for (g = 0; g < `SRC_COUNT; g = g + 1) begin : src
      reg  s1;
      reg  s2;
      reg  s3;
      wire rise;
      wire fall;
      wire [1:0] mode;
      assign mode = edge_sel[2*g+1:2*g];
      assign rise = s2 & ~s3;
      assign fall = ~s2 & s3;
      // edge detect where second and third stage disagree
      assign hit[g] = (mode == `EDGE_RISE) ? rise :
                      (mode == `EDGE_FALL) ? fall : (rise | fall);
      always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= src_raw[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // set wins over a same-cycle clear; enable plays no part
      always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          flags[g] <= 1'b0;
        end else if (hit[g]) begin
          flags[g] <= 1'b1;
        end else if (i_flag_wr & ~i_flag_wdata[g]) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pending = |(flags & irq_enable_reg);
  assign o_irq_flags         = flags;
  assign o_irq_enable_reg    = irq_enable_reg;
  assign o_edge_select       = edge_sel;
  assign o_stack_pointer_reg = stack_pointer_reg;
  assign o_global_enable     = gie;
  assign o_busy              = (state != ST_IDLE);

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_enable_reg <= `ENABLE_RESET;
      edge_sel       <= `EDGE_RESET;
    end else begin
      if (i_enable_wr) begin
        irq_enable_reg <= i_enable_wdata;
      end
      if (i_edge_wr) begin
        edge_sel <= i_edge_wdata;
      end
    end
  end

  // command decode; entry outranks the sequencer commands
  assign start_entry = (state == ST_IDLE) & i_boundary & gie & pending;
  assign start_reti  = (state == ST_IDLE) & ~start_entry & i_reti;
  assign start_push  = (state == ST_IDLE) & ~start_entry & ~i_reti & i_push;
  assign start_pop   = (state == ST_IDLE) & ~start_entry & ~i_reti & ~i_push & i_pop;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_entry) begin
          next_state = ST_ENT1;
        end else if (start_reti) begin
          next_state = ST_RET0;
        end else if (start_push) begin
          next_state = ST_PUSH1;
        end else if (start_pop) begin
          next_state = ST_POP0;
        end
      end
      ST_ENT1:  next_state = ST_IDLE;
      ST_RET0:  next_state = ST_RET1;
      ST_RET1:  next_state = ST_RET2;
      ST_RET2:  next_state = ST_IDLE;
      ST_PUSH1: next_state = ST_IDLE;
      ST_POP0:  next_state = ST_POP1;
      ST_POP1:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always @* begin
    next_sp = stack_pointer_reg;
    case (state)
      ST_IDLE: begin
        if (i_sp_wr) begin
          next_sp = {i_sp_wdata[7:1], 1'b0};
        end
      end
      ST_ENT1:  next_sp = stack_pointer_reg + `SP_STEP;
      ST_RET2:  next_sp = stack_pointer_reg - `SP_STEP;
      ST_PUSH1: next_sp = stack_pointer_reg + `SP_STEP;
      ST_POP1:  next_sp = stack_pointer_reg - `SP_STEP;
      default:  next_sp = stack_pointer_reg;
    endcase
  end

  always @* begin
    next_gie = gie;
    if (state == ST_IDLE) begin
      if (i_engint) begin
        next_gie = 1'b1;
      end else if (i_disgint) begin
        next_gie = 1'b0;
      end
      if (start_entry) begin
        next_gie = 1'b0;
      end
    end else if (state == ST_RET2) begin
      next_gie = 1'b1;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state             <= ST_IDLE;
      gie               <= 1'b0;
      stack_pointer_reg <= `SP_RESET;
    end else begin
      state             <= next_state;
      gie               <= next_gie;
      stack_pointer_reg <= next_sp;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_byte       <= 8'h00;
      save_pc       <= 16'h0000;
      save_sflag    <= 8'h00;
      o_take        <= 1'b0;
      o_pc_load     <= 1'b0;
      o_pc_value    <= 16'h0000;
      o_acc_load    <= 1'b0;
      o_acc_value   <= 8'h00;
      o_sflag_load  <= 1'b0;
      o_sflag_value <= 8'h00;
      o_mem_we      <= 1'b0;
      o_mem_addr    <= 8'h00;
      o_mem_wdata   <= 8'h00;
    end else begin
      o_take       <= 1'b0;
      o_pc_load    <= 1'b0;
      o_acc_load   <= 1'b0;
      o_sflag_load <= 1'b0;
      o_mem_we     <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_entry) begin
            // low pc byte first, high byte next cycle
            o_take      <= 1'b1;
            o_mem_we    <= 1'b1;
            o_mem_addr  <= stack_pointer_reg;
            o_mem_wdata <= i_pc[7:0];
            save_pc     <= i_pc;
          end else if (start_reti) begin
            o_mem_addr <= stack_pointer_reg - `SP_STEP;
          end else if (start_push) begin
            o_mem_we    <= 1'b1;
            o_mem_addr  <= stack_pointer_reg;
            o_mem_wdata <= i_accumulator;
            save_sflag  <= i_status_flags;
          end else if (start_pop) begin
            o_mem_addr <= stack_pointer_reg - `SP_STEP;
          end
          // pop tail: flags byte arrives one cycle after the accumulator byte
          if (o_acc_load) begin
            o_sflag_load  <= 1'b1;
            o_sflag_value <= i_mem_rdata;
          end
        end
        ST_ENT1: begin
          o_mem_we    <= 1'b1;
          o_mem_addr  <= stack_pointer_reg + 8'h01;
          o_mem_wdata <= save_pc[15:8];
          o_pc_load   <= 1'b1;
          o_pc_value  <= `VECTOR_ADDR;
        end
        ST_RET0: begin
          // memory answers one cycle after the address
          o_mem_addr <= stack_pointer_reg - 8'h01;
        end
        ST_RET1: begin
          lo_byte <= i_mem_rdata;
        end
        ST_RET2: begin
          o_pc_load  <= 1'b1;
          o_pc_value <= {i_mem_rdata, lo_byte};
        end
        ST_PUSH1: begin
          o_mem_we    <= 1'b1;
          o_mem_addr  <= stack_pointer_reg + 8'h01;
          o_mem_wdata <= save_sflag;
        end
        ST_POP0: begin
          o_mem_addr <= stack_pointer_reg - 8'h01;
        end
        ST_POP1: begin
          o_acc_load  <= 1'b1;
          o_acc_value <= i_mem_rdata;
        end
        default: begin
          o_mem_we <= 1'b0;
        end
      endcase
    end
  end

endmodule // irq_ctrl

// ### core/irq_ctrl_defines.vh
// constants for the interrupt controller
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH
`define SRC_COUNT      4
`define SRC_PIN        0
`define SRC_CMP        1
`define SRC_T16        2
`define SRC_T8         3
`define VECTOR_ADDR    16'h0010
`define SP_STEP        8'h02
`define SP_RESET       8'h00
`define FLAGS_RESET    4'h0
`define ENABLE_RESET   4'h0
`define EDGE_RESET     8'h00
`define EDGE_RISE      2'h1
`define EDGE_FALL      2'h2
`define EDGE_BOTH      2'h0
`endif

// ### dv/irq_ctrl_sva.sv
// port assertions for the interrupt controller
`timescale 1ns/100ps
module irq_ctrl_sva (
  input wire        i_ref_clk, i_rst, i_boundary, i_pop, i_flag_wr, i_reti, i_push,
  input wire [3:0]  i_flag_wdata, o_irq_flags, o_irq_enable_reg,
  input wire [7:0]  o_stack_pointer_reg, o_mem_addr,
  input wire        o_global_enable, o_busy, o_take, o_pc_load, o_mem_we,
  input wire        o_acc_load, o_sflag_load,
  input wire [15:0] o_pc_value
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire pend = i_boundary && o_global_enable && |(o_irq_flags & o_irq_enable_reg) && !o_busy;
  property p_take; pend |=> o_take; endproperty
  a_take: assert property (p_take) else $error("entry missed");
  property p_gate; o_take |-> $past(pend); endproperty
  a_gate: assert property (p_gate) else $error("entry without cause");
  property p_vec; o_take |=> o_pc_load && o_pc_value == 16'h0010; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_wr; o_take |-> o_mem_we && o_mem_addr == o_stack_pointer_reg
    ##1 o_mem_we && o_mem_addr == $past(o_stack_pointer_reg) + 8'h01; endproperty
  a_wr: assert property (p_wr) else $error("pc not stacked");
  property p_sp; o_take |-> ##2 o_stack_pointer_reg == $past(o_stack_pointer_reg, 2) + 8'h02;
  endproperty
  a_sp: assert property (p_sp) else $error("sp not advanced");
  property p_gie; o_take |-> ##2 !o_global_enable; endproperty
  a_gie: assert property (p_gie) else $error("global enable kept");
  property p_even; o_stack_pointer_reg[0] == 1'b0; endproperty
  a_even: assert property (p_even) else $error("sp odd");
  property p_clr; |($past(o_irq_flags) & ~o_irq_flags) |-> $past(i_flag_wr)
    && ($past(o_irq_flags) & ~o_irq_flags & $past(i_flag_wdata)) == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("flag lost");
  property p_pop; i_pop && !i_reti && !i_push && !o_busy && !pend
    |-> ##3 o_acc_load ##1 o_sflag_load; endproperty
  a_pop: assert property (p_pop) else $error("pop order");
  c_take: cover property (o_take);
  c_pop: cover property (o_sflag_load);
  c_clr: cover property (i_flag_wr && o_irq_flags != 4'h0);
endmodule // irq_ctrl_sva
bind irq_ctrl irq_ctrl_sva u_irq_ctrl_sva (.*);

// ### dv/irq_mem_model.sv
// core data memory, read data one cycle after address
`timescale 1ns/100ps
module irq_mem_model (
  input  wire       i_ref_clk,
  input  wire       i_we,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata
);
  reg [7:0] mem [0:255];
  integer   k;
  initial begin
    o_rdata = 8'h00;
    for (k = 0; k < 256; k = k + 1) mem[k] = ~k[7:0];
  end
  always @(posedge i_ref_clk) begin
    if (i_we) mem[i_addr] <= i_wdata;
    o_rdata <= mem[i_addr];
  end
endmodule // irq_mem_model

// ### dv/irq_ctrl_tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`include "irq_ctrl_defines.vh"
module irq_ctrl_tb_top;
  reg         clk, rst, bnd;
  reg  [3:0]  src, wrs;
  reg  [4:0]  cmdv;
  reg  [7:0]  wdat, acc, sf, hi, lo, acc_seen, sf_seen, stk[$];
  reg  [15:0] pc, pc_seen;
  wire [3:0]  flags, enr;
  wire [7:0]  egs, sp, addr, wd, rd, accv, sfv;
  wire [15:0] pcv;
  wire        gie, busy, take, pcl, accl, sfl, we;
  integer     errors, samples_checked, seed, ntake, g, m, spm, r;
  irq_ctrl u_irq_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_external_pin_source(src[0]),
    .i_comparator_source(src[1]), .i_sixteen_bit_timer_source(src[2]),
    .i_eight_bit_timer_source(src[3]), .i_enable_wr(wrs[3]), .i_enable_wdata(wdat[3:0]),
    .i_edge_wr(wrs[1]), .i_edge_wdata(wdat), .i_flag_wr(wrs[2]), .i_flag_wdata(wdat[3:0]),
    .i_sp_wr(wrs[0]), .i_sp_wdata(wdat), .i_engint(cmdv[4]), .i_disgint(cmdv[3]),
    .i_boundary(bnd), .i_pc(pc), .i_reti(cmdv[2]), .i_push(cmdv[1]), .i_pop(cmdv[0]),
    .i_accumulator(acc), .i_status_flags(sf), .i_mem_rdata(rd), .o_irq_flags(flags),
    .o_irq_enable_reg(enr), .o_edge_select(egs), .o_stack_pointer_reg(sp),
    .o_global_enable(gie), .o_busy(busy), .o_take(take), .o_pc_load(pcl), .o_pc_value(pcv),
    .o_acc_load(accl), .o_acc_value(accv), .o_sflag_load(sfl), .o_sflag_value(sfv),
    .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wd));
  irq_mem_model u_irq_mem_model (.i_ref_clk(clk), .i_we(we), .i_addr(addr), .i_wdata(wd),
    .o_rdata(rd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (take) ntake <= ntake + 1;
    if (pcl) pc_seen <= pcv;
    if (accl) acc_seen <= accv;
    if (sfl) sf_seen <= sfv;
  end
  task tally_and_finish;
    begin
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [3:0] s, input [7:0] d);
    begin
      @(posedge clk) {wrs, wdat} <= {s, d};
      @(posedge clk) wrs <= 4'h0;
    end
  endtask
  task cmd(input [4:0] c);
    begin
      @(posedge clk) cmdv <= c;
      @(posedge clk) cmdv <= 5'h00;
      cyc(8);
    end
  endtask
  task idle;
    integer t;
    for (t = 0; busy !== 1'b0; t = t + 1) begin
      if (t > 40) begin
        errors = errors + 1;
        tally_and_finish;
      end
      cyc(1);
    end
  endtask
  initial begin
    {bnd, src, wrs, cmdv, wdat, pc, acc, sf} = 0;
    {errors, samples_checked, ntake} = 0;
    {rst, seed} = {1'b1, 32'd80};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({gie, flags, enr, egs, sp}, {1'b0, `FLAGS_RESET, `ENABLE_RESET, `EDGE_RESET,
      `SP_RESET});
    $display("reset test done");
    for (g = 0; g < 4; g = g + 1) for (m = 0; m < 4; m = m + 1) begin
      wr(4'h2, {4{m[1:0]}});
      wr(4'h4, 8'h00);
      chk(egs, {4{m[1:0]}});
      @(posedge clk) src[g] <= 1'b1;
      cyc(6);
      chk(flags, (m != 2) << g);
      wr(4'h4, 8'h00);
      @(posedge clk) src[g] <= 1'b0;
      cyc(6);
      chk(flags, (m != 1) << g);
    end
    $display("edge test done");
    @(posedge clk) src <= 4'hf;
    cyc(6);
    wr(4'h4, 8'h0b);
    cyc(1);
    chk(flags, 4'hb);
    spm = $random(seed) & 8'h7f;
    wr(4'h1, spm[7:0] | 8'h01);
    spm = spm & 8'h7e;
    cyc(1);
    chk(sp, spm);
    r = $random(seed);
    @(posedge clk) pc <= r[15:0];
    cmd(5'h10);
    cmd(5'h08);
    chk(gie, 0);
    cmd(5'h10);
    chk({ntake, gie}, 1);
    wr(4'h8, 8'h08);
    cyc(8);
    chk(ntake, 0);
    chk(enr, 4'h8);
    @(posedge clk) bnd <= 1'b1;
    cyc(8);
    idle;
    stk.push_back(pc[7:0]);
    stk.push_back(pc[15:8]);
    spm = spm + 2;
    chk(ntake, 1);
    chk({pc_seen, sp, gie}, {`VECTOR_ADDR, spm[7:0], 1'b0});
    $display("entry test done");
    @(posedge clk) bnd <= 1'b0;
    wr(4'h4, 8'h07);
    cmd(5'h04);
    idle;
    hi = stk.pop_back();
    lo = stk.pop_back();
    spm = spm - 2;
    chk({pc_seen, sp, gie, flags}, {hi, lo, spm[7:0], 1'b1, 4'h3});
    $display("return test done");
    r = $random(seed);
    @(posedge clk) {acc, sf} <= r[15:0];
    cmd(5'h02);
    idle;
    cmd(5'h01);
    idle;
    chk({acc_seen, sf_seen, sp}, {r[15:8], r[7:0], spm[7:0]});
    $display("push pop test done");
    tally_and_finish;
  end
endmodule // irq_ctrl_tb_top
